// ---- design/fem_device.sv ----
// Flash erase/write sequencer with data memory map decode
`timescale 1ns/10ps
`default_nettype none
module fem_device (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Processor side
  fem_if.dev bus,
  // System status
  input wire logic emulator_port,
  input wire logic engine_running,
  input wire logic access_pulse_width_sel,
  // Flash status
  output logic flash_busy,
  output logic flash_pulse_long
);
  import fem_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    FEM_ST_IDLE = 2'b00,
    FEM_ST_MASS = 2'b01,
    FEM_ST_PAGE = 2'b10
  } fem_est_t;

  typedef struct packed {
    fem_est_t st;
    logic mass_erase_arm;
    logic program_write_steer;
    logic [PAGE_BITS-1:0] erase_page_select;
    logic [15:0] ptr;
    logic [2:0] wcnt;
    logic [7:0] rdata;
    logic [7:0] sfr_rdata;
  } fem_dev_t;

  fem_dev_t s_r;
  fem_dev_t s_nxt;

  // Memories
  logic [7:0] flash_mem [FLASH_BYTES];
  logic [7:0] cpu_ram [CPU_RAM_BYTES];
  logic [7:0] edata_ram [ENG_DATA_BYTES];
  logic [7:0] cfg_ram [CFG_RAM_BYTES];
  logic [7:0] eprog_ram [ENG_PROG_BYTES];

  fem_region_t region;
  logic slow;
  logic go;
  logic blocked;
  logic erasing;
  logic [7:0] ram_byte;
  logic [15:0] eptr_end;

  // Region decode; CPU RAM wins at the bottom for RAM access
  always_comb begin
    region = FEM_RG_FLASH;
    if (bus.mem_addr <= CPU_RAM_HI) begin
      region = FEM_RG_CPU;
    end else if (bus.mem_addr >= ENG_DATA_LO && bus.mem_addr <= ENG_DATA_HI) begin
      region = FEM_RG_EDATA;
    end else if (bus.mem_addr >= CFG_RAM_LO && bus.mem_addr <= CFG_RAM_HI) begin
      region = FEM_RG_CFG;
    end else if (bus.mem_addr >= ENG_PROG_LO && bus.mem_addr <= ENG_PROG_HI) begin
      region = FEM_RG_EPROG;
    end
  end

  // Engine RAMs are slow; program RAM is locked while the engine runs
  assign slow = (region == FEM_RG_EDATA) || (region == FEM_RG_EPROG);
  assign blocked = (region == FEM_RG_EPROG) && engine_running;
  assign go = (bus.mem_wr || bus.mem_rd) && (!slow || s_r.wcnt == ENG_WAIT_STATES);
  assign erasing = (s_r.st != FEM_ST_IDLE);
  assign eptr_end = s_r.st == FEM_ST_MASS ? 16'hFFFF
                  : {s_r.erase_page_select, {PAGE_OFS_BITS{1'b1}}};

  // Selected RAM byte for reads
  always_comb begin
    ram_byte = 8'h00;
    case (region)
      FEM_RG_CPU: ram_byte = cpu_ram[bus.mem_addr[10:0]];
      FEM_RG_EDATA: ram_byte = edata_ram[bus.mem_addr[9:0]];
      FEM_RG_CFG: ram_byte = cfg_ram[bus.mem_addr[7:0]];
      FEM_RG_EPROG: ram_byte = blocked ? 8'h00 : eprog_ram[bus.mem_addr[11:0]];
      default: ram_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    // Wait state counter: counts while a slow access is pending
    if ((bus.mem_wr || bus.mem_rd) && slow && !go) begin
      s_nxt.wcnt = s_r.wcnt + 3'h1;
    end else begin
      s_nxt.wcnt = ZERO_WAIT_STATES;
    end
    if (go && bus.mem_rd) begin
      s_nxt.rdata = (region == FEM_RG_FLASH) ? flash_mem[bus.mem_addr] : ram_byte;
    end
    // SFR writes
    if (bus.sfr_wr && bus.sfr_addr == SFR_CONTROL_BITS) begin
      s_nxt.program_write_steer = bus.sfr_wdata[CTL_STEER_BIT];
      s_nxt.mass_erase_arm = bus.sfr_wdata[CTL_ARM_BIT];
    end
    if (bus.sfr_wr && bus.sfr_addr == SFR_PAGE_SELECT) begin
      s_nxt.erase_page_select = bus.sfr_wdata[7:PAGE_LSB];
    end
    // Only the exact pattern starts an erase; mass erase also needs the arm bit and the emulator port
    if (bus.sfr_wr && bus.sfr_addr == SFR_ERASE_PATTERN && !erasing) begin
      if (bus.sfr_wdata == PAT_MASS && s_r.mass_erase_arm && emulator_port) begin
        s_nxt.st = FEM_ST_MASS;
        s_nxt.ptr = 16'h0000;
        s_nxt.mass_erase_arm = 1'b0;
      end else if (bus.sfr_wdata == PAT_PAGE) begin
        s_nxt.st = FEM_ST_PAGE;
        s_nxt.ptr = {s_r.erase_page_select, {PAGE_OFS_BITS{1'b0}}};
      end else begin
        s_nxt.mass_erase_arm = 1'b0;
      end
    end
    // Erase walks one byte per clock
    case (s_r.st)
      FEM_ST_IDLE: begin
      end
      FEM_ST_MASS, FEM_ST_PAGE: begin
        s_nxt.ptr = s_r.ptr + 16'h0001;
        if (s_r.ptr == eptr_end) begin
          s_nxt.st = FEM_ST_IDLE;
        end
      end
      default: s_nxt.st = FEM_ST_IDLE;
    endcase
    // SFR read data
    s_nxt.sfr_rdata = 8'h00;
    if (bus.sfr_rd) begin
      case (bus.sfr_addr)
        SFR_CONTROL_BITS: begin
          s_nxt.sfr_rdata[CTL_STEER_BIT] = s_r.program_write_steer;
          s_nxt.sfr_rdata[CTL_ARM_BIT] = s_r.mass_erase_arm;
          s_nxt.sfr_rdata[CTL_BUSY_BIT] = erasing;
        end
        SFR_PAGE_SELECT: s_nxt.sfr_rdata = {s_r.erase_page_select, 1'b0};
        default: s_nxt.sfr_rdata = 8'h00;
      endcase
    end
    if (sys_rst) begin
      s_nxt = '0;
      s_nxt.st = FEM_ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // ****************************************
  // Memory writes
  // ****************************************
  // Flash programming only clears bits; erase sets bytes to 0xFF
  always_ff @(posedge clk) begin
    if (erasing) begin
      flash_mem[s_r.ptr] <= ERASED_BYTE;
    end else if (go && bus.mem_wr && s_r.program_write_steer) begin
      flash_mem[bus.mem_addr] <= flash_mem[bus.mem_addr] & bus.mem_wdata;
    end
  end

  // RAM cells take every store not blocked by the running engine, also those steered to flash
  always_ff @(posedge clk) begin
    if (go && bus.mem_wr) begin
      case (region)
        FEM_RG_CPU: cpu_ram[bus.mem_addr[10:0]] <= bus.mem_wdata;
        FEM_RG_EDATA: edata_ram[bus.mem_addr[9:0]] <= bus.mem_wdata;
        FEM_RG_CFG: cfg_ram[bus.mem_addr[7:0]] <= bus.mem_wdata;
        FEM_RG_EPROG: begin
          if (!blocked) begin
            eprog_ram[bus.mem_addr[11:0]] <= bus.mem_wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Outputs
  assign bus.mem_wait = (bus.mem_wr || bus.mem_rd) && !go;
  assign bus.mem_rdata = s_r.rdata;
  assign bus.sfr_rdata = s_r.sfr_rdata;
  assign flash_busy = erasing;
  assign flash_pulse_long = access_pulse_width_sel;

endmodule : fem_device
`default_nettype wire

// ---- inc/fem_pkg.sv ----
// Package: flash sequencer and memory map constants and types
package fem_pkg;

  // ****************************************
  // SFR offsets
  // ****************************************
  localparam logic [7:0] SFR_ERASE_PATTERN = 8'h94;
  localparam logic [7:0] SFR_CONTROL_BITS = 8'hB2;
  localparam logic [7:0] SFR_PAGE_SELECT = 8'hB7;

  // Field positions
  localparam int CTL_STEER_BIT = 0;
  localparam int CTL_ARM_BIT = 1;
  localparam int CTL_BUSY_BIT = 7;
  localparam int PAGE_LSB = 1;

  // Erase patterns
  localparam logic [7:0] PAT_MASS = 8'hAA;
  localparam logic [7:0] PAT_PAGE = 8'h55;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // Memory map
  // ****************************************
  localparam logic [15:0] CPU_RAM_LO = 16'h0000;
  localparam logic [15:0] CPU_RAM_HI = 16'h07FF;
  localparam logic [15:0] ENG_DATA_LO = 16'h1000;
  localparam logic [15:0] ENG_DATA_HI = 16'h13FF;
  localparam logic [15:0] CFG_RAM_LO = 16'h2000;
  localparam logic [15:0] CFG_RAM_HI = 16'h20FF;
  localparam logic [15:0] CFG_CRIT_HI = 16'h2007;
  localparam logic [15:0] ENG_PROG_LO = 16'h3000;
  localparam logic [15:0] ENG_PROG_HI = 16'h3FFF;
  localparam logic [2:0] ENG_WAIT_STATES = 3'h5;
  localparam logic [2:0] ZERO_WAIT_STATES = 3'h0;

  // Flash geometry: 128 pages of 512 bytes
  localparam int FLASH_BYTES = 65536;
  localparam int PAGE_BITS = 7;
  localparam int PAGE_OFS_BITS = 9;
  localparam int CPU_RAM_BYTES = 2048;
  localparam int ENG_DATA_BYTES = 1024;
  localparam int CFG_RAM_BYTES = 256;
  localparam int ENG_PROG_BYTES = 4096;

  // Avalon register map of the controller
  localparam logic [3:0] AV_CTRL = 4'h0;
  localparam logic [3:0] AV_ADDR = 4'h4;
  localparam logic [3:0] AV_WDATA = 4'h8;
  localparam logic [3:0] AV_STATUS = 4'hC;
  localparam int AV_GO_BIT = 0;
  localparam int AV_KIND_LSB = 1;

  // Controller operation kinds
  typedef enum logic [1:0] {
    FEM_OP_SFR_WR = 2'b00,
    FEM_OP_SFR_RD = 2'b01,
    FEM_OP_MEM_WR = 2'b10,
    FEM_OP_MEM_RD = 2'b11
  } fem_op_t;

  // Device region decode
  typedef enum logic [2:0] {
    FEM_RG_FLASH = 3'b000,
    FEM_RG_CPU = 3'b001,
    FEM_RG_EDATA = 3'b010,
    FEM_RG_CFG = 3'b011,
    FEM_RG_EPROG = 3'b100
  } fem_region_t;

endpackage : fem_pkg

// ---- inc/fem_if.sv ----
// Interface: processor-side SFR and external data bus between core and flash block
`timescale 1ns/10ps
`default_nettype none
interface fem_if (
  input wire logic clk
);
  // SFR port
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  // External data port
  logic mem_wr;
  logic mem_rd;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic mem_wait;

  modport dev (
    input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, mem_wr, mem_rd, mem_addr, mem_wdata,
    output sfr_rdata, mem_rdata, mem_wait
  );
  modport cpu (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, mem_wr, mem_rd, mem_addr, mem_wdata,
    input sfr_rdata, mem_rdata, mem_wait
  );
endinterface : fem_if
`default_nettype wire

// ---- design/fem_cpu.sv ----
// Processor-side controller: Avalon-MM orders into SFR and external bus cycles
`timescale 1ns/10ps
`default_nettype none
module fem_cpu (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Device side
  fem_if.cpu bus
);
  import fem_pkg::*;

  typedef enum logic [1:0] {
    FEM_CS_IDLE = 2'b00,
    FEM_CS_RUN = 2'b01,
    FEM_CS_DONE = 2'b10
  } fem_cst_t;

  typedef struct packed {
    fem_cst_t st;
    fem_op_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    logic [31:0] rd;
  } fem_cpu_t;

  fem_cpu_t s_r;
  fem_cpu_t s_nxt;
  logic run;
  logic acc;

  assign run = (s_r.st == FEM_CS_RUN);
  assign acc = avs_read || avs_write;

  // Sequencer; software itself keeps the steer and erase ordering rules
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd = 32'h0000_0000;
    // Writes land only at the edge that also sees waitrequest low
    if (avs_write && !avs_waitrequest) begin
      case (avs_address)
        AV_CTRL: begin
          if (avs_writedata[AV_GO_BIT] && !s_r.busy) begin
            s_nxt.kind = fem_op_t'(avs_writedata[AV_KIND_LSB +: 2]);
            s_nxt.st = FEM_CS_RUN;
            s_nxt.busy = 1'b1;
          end
        end
        AV_ADDR: s_nxt.addr = avs_writedata[15:0];
        AV_WDATA: s_nxt.wdata = avs_writedata[7:0];
        default: begin
        end
      endcase
    end
    if (avs_read) begin
      case (avs_address)
        AV_ADDR: s_nxt.rd = {16'h0000, s_r.addr};
        AV_WDATA: s_nxt.rd = {24'h000000, s_r.wdata};
        AV_STATUS: s_nxt.rd = {23'h000000, s_r.busy, s_r.rdata};
        default: s_nxt.rd = 32'h0000_0000;
      endcase
    end
    case (s_r.st)
      FEM_CS_IDLE: begin
      end
      FEM_CS_RUN: begin
        if (s_r.kind == FEM_OP_SFR_WR || s_r.kind == FEM_OP_SFR_RD || !bus.mem_wait) begin
          s_nxt.st = FEM_CS_DONE;
        end
      end
      FEM_CS_DONE: begin
        s_nxt.st = FEM_CS_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.rdata = (s_r.kind == FEM_OP_SFR_RD) ? bus.sfr_rdata : bus.mem_rdata;
      end
      default: s_nxt.st = FEM_CS_IDLE;
    endcase
    if (sys_rst) begin
      s_nxt = '0;
      s_nxt.st = FEM_CS_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  // Avalon answers one cycle after the access is presented
  logic ack_r;
  always_ff @(posedge clk) begin
    ack_r <= sys_rst ? 1'b0 : (acc && !ack_r);
  end
  assign avs_waitrequest = acc && !ack_r;
  assign avs_readdata = ack_r ? s_r.rd : 32'h0000_0000;

  // Bus strobes
  assign bus.sfr_wr = run && s_r.kind == FEM_OP_SFR_WR;
  assign bus.sfr_rd = run && s_r.kind == FEM_OP_SFR_RD;
  assign bus.sfr_addr = s_r.addr[7:0];
  assign bus.sfr_wdata = s_r.wdata;
  assign bus.mem_wr = run && s_r.kind == FEM_OP_MEM_WR;
  assign bus.mem_rd = run && s_r.kind == FEM_OP_MEM_RD;
  assign bus.mem_addr = s_r.addr;
  assign bus.mem_wdata = s_r.wdata;

endmodule : fem_cpu
`default_nettype wire

// ---- sim/fem_checker.sv ----
// Checker: wait-state and erase-guard properties on the core-to-flash link
`timescale 1ns/10ps
`default_nettype none
module fem_checker
  import fem_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Interface signals
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic mem_wait,
  // Device status
  input wire logic emulator_port,
  input wire logic access_pulse_width_sel,
  input wire logic flash_busy,
  input wire logic flash_pulse_long
);
  // ****
  // Helper logic
  // ****
  logic eng_hit;
  logic erase_wr;
  logic [16:0] busy_cnt_r;
  logic [16:0] busy_cnt_nxt;
  // Engine data or program window
  assign eng_hit = (mem_addr >= ENG_DATA_LO && mem_addr <= ENG_DATA_HI) ||
                   (mem_addr >= ENG_PROG_LO && mem_addr <= ENG_PROG_HI);
  // Pattern writes count only while idle; busy writes are ignored
  assign erase_wr = sfr_wr && sfr_addr == SFR_ERASE_PATTERN && !flash_busy;
  // Busy run length; far too long for a fixed delay range
  assign busy_cnt_nxt = flash_busy ? busy_cnt_r + 17'h1 : 17'h0;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_cnt_r <= 17'h0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Properties
  // ****
  property p_eng_wait;
    $rose(mem_rd || mem_wr) && eng_hit |-> mem_wait [*5] ##1 !mem_wait;
  endproperty
  a_eng_wait: assert property (p_eng_wait) else $error("engine wait not five");
  property p_zero_wait;
    (mem_rd || mem_wr) && !eng_hit |-> !mem_wait;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("wait on fast region");
  property p_mass_refused;
    erase_wr && sfr_wdata == PAT_MASS && !emulator_port |=> !flash_busy;
  endproperty
  a_mass_refused: assert property (p_mass_refused) else $error("mass erase ran");
  property p_page_start;
    erase_wr && sfr_wdata == PAT_PAGE |=> flash_busy [*8];
  endproperty
  a_page_start: assert property (p_page_start) else $error("page erase missing");
  property p_junk;
    erase_wr && sfr_wdata != PAT_MASS && sfr_wdata != PAT_PAGE |=> !flash_busy;
  endproperty
  a_junk: assert property (p_junk) else $error("erase on bad pattern");
  property p_pulse;
    flash_pulse_long == access_pulse_width_sel;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width select lost");
  property p_rst_idle;
    $fell(sys_rst) |-> !flash_busy;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  property p_busy_bound;
    busy_cnt_r <= 17'h10004;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("erase never ends");
endmodule : fem_checker
`default_nettype wire

// ---- sim/flash_erase_write_and_memory_map_tb_top.sv ----
// Testbench: controller and flash block joined, driven over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module flash_erase_write_and_memory_map_tb_top;
  import fem_pkg::*;
  // ****
  // Signals and instances
  // ****
  typedef struct {fem_op_t k; logic [15:0] a; logic [7:0] d;} fem_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic emulator_port = 1'b0;
  logic engine_running = 1'b0;
  logic access_pulse_width_sel = 1'b0;
  logic flash_busy;
  logic flash_pulse_long;
  logic [7:0] rd_v;
  logic [31:0] q_v;
  int fails = 0;
  int n_checks = 0;
  // Reads carry the expected byte in d
  fem_row_t rows [13] = '{
    '{FEM_OP_SFR_RD, 16'h00B2, 8'h00}, '{FEM_OP_SFR_WR, 16'h00B7, 8'h06},
    '{FEM_OP_SFR_RD, 16'h00B7, 8'h06}, '{FEM_OP_MEM_WR, 16'h0000, 8'h3C},
    '{FEM_OP_MEM_WR, 16'h07FF, 8'h5A}, '{FEM_OP_MEM_WR, 16'h1000, 8'hA5},
    '{FEM_OP_MEM_WR, 16'h20FF, 8'h81}, '{FEM_OP_MEM_WR, 16'h3FFF, 8'h42},
    '{FEM_OP_MEM_RD, 16'h0000, 8'h3C}, '{FEM_OP_MEM_RD, 16'h07FF, 8'h5A},
    '{FEM_OP_MEM_RD, 16'h1000, 8'hA5}, '{FEM_OP_MEM_RD, 16'h20FF, 8'h81},
    '{FEM_OP_MEM_RD, 16'h3FFF, 8'h42}};
  fem_if bus_if (.clk(clk));
  fem_cpu fem_cpu_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(bus_if));
  fem_device fem_device_i (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
    .emulator_port(emulator_port), .engine_running(engine_running),
    .access_pulse_width_sel(access_pulse_width_sel), .flash_busy(flash_busy),
    .flash_pulse_long(flash_pulse_long));
  fem_checker fem_checker_i (.clk(clk), .sys_rst(sys_rst), .sfr_wr(bus_if.sfr_wr),
    .sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata), .mem_wr(bus_if.mem_wr),
    .mem_rd(bus_if.mem_rd), .mem_addr(bus_if.mem_addr), .mem_wait(bus_if.mem_wait),
    .emulator_port(emulator_port), .access_pulse_width_sel(access_pulse_width_sel),
    .flash_busy(flash_busy), .flash_pulse_long(flash_pulse_long));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One Avalon cycle, held until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) fails++;
    q_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : av
  // Full controller order, then poll status until idle
  task automatic op(input fem_op_t k, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    av(1'b1, AV_ADDR, {16'h0, a});
    av(1'b1, AV_WDATA, {24'h0, d});
    av(1'b1, AV_CTRL, {29'h0, k, 1'b1});
    q_v = 32'h100;
    while (q_v[8] !== 1'b0 && n < 100) begin
      av(1'b0, AV_STATUS, 32'h0);
      n++;
    end
    if (n >= 100) fails++;
    rd_v = q_v[7:0];
  endtask : op
  task automatic wait_idle();
    int n;
    n = 0;
    while (flash_busy !== 1'b0 && n < 70000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 70000) fails++;
  endtask : wait_idle
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // ****
  // Clock, watchdog and sequence
  // ****
  initial begin
    forever #50 clk = ~clk;
  end
  // Mass erase dominates; about 70k cycles expected
  initial begin
    #(100 * 95000);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      op(rows[i].k, rows[i].a, rows[i].d);
      if (rows[i].k == FEM_OP_SFR_RD || rows[i].k == FEM_OP_MEM_RD) begin
        chk(rd_v, rows[i].d);
      end
    end
    // Armed mass erase with the emulator port on
    emulator_port <= 1'b1;
    op(FEM_OP_SFR_WR, 16'h00B2, 8'h02);
    op(FEM_OP_SFR_WR, 16'h0094, PAT_MASS);
    chk({7'h0, flash_busy}, 8'h01);
    wait_idle();
    op(FEM_OP_SFR_RD, 16'h00B2, 8'h00);
    chk(rd_v, 8'h00);
    op(FEM_OP_MEM_RD, 16'h8001, 8'h00);
    chk(rd_v, ERASED_BYTE);
    // Steered stores only clear bits and also hit RAM
    op(FEM_OP_SFR_WR, 16'h00B2, 8'h01);
    op(FEM_OP_MEM_WR, 16'h8001, 8'h0F);
    op(FEM_OP_MEM_WR, 16'h8001, 8'hF0);
    op(FEM_OP_MEM_WR, 16'h8200, 8'h3C);
    op(FEM_OP_MEM_WR, 16'h2010, 8'h66);
    op(FEM_OP_SFR_WR, 16'h00B2, 8'h00);
    op(FEM_OP_MEM_WR, 16'h8002, 8'h12);
    op(FEM_OP_MEM_RD, 16'h2010, 8'h00);
    chk(rd_v, 8'h66);
    op(FEM_OP_MEM_RD, 16'h8002, 8'h00);
    chk(rd_v, ERASED_BYTE);
    // Junk, unarmed and unemulated erase attempts
    op(FEM_OP_SFR_WR, 16'h0094, 8'h12);
    op(FEM_OP_SFR_WR, 16'h0094, PAT_MASS);
    emulator_port <= 1'b0;
    op(FEM_OP_SFR_WR, 16'h00B2, 8'h02);
    op(FEM_OP_SFR_WR, 16'h0094, PAT_MASS);
    chk({7'h0, flash_busy}, 8'h00);
    op(FEM_OP_MEM_RD, 16'h8001, 8'h00);
    chk(rd_v, 8'h00);
    // Page 64 erase leaves page 65 alone
    op(FEM_OP_SFR_WR, 16'h00B7, 8'h80);
    op(FEM_OP_SFR_WR, 16'h0094, PAT_PAGE);
    chk({7'h0, flash_busy}, 8'h01);
    wait_idle();
    op(FEM_OP_MEM_RD, 16'h8001, 8'h00);
    chk(rd_v, ERASED_BYTE);
    op(FEM_OP_MEM_RD, 16'h8200, 8'h00);
    chk(rd_v, 8'h3C);
    // Program RAM blocked while the engine runs; data RAM stays open
    engine_running <= 1'b1;
    op(FEM_OP_MEM_WR, 16'h3FFF, 8'h99);
    op(FEM_OP_MEM_RD, 16'h3FFF, 8'h00);
    chk(rd_v, 8'h00);
    op(FEM_OP_MEM_RD, 16'h1000, 8'h00);
    chk(rd_v, 8'hA5);
    engine_running <= 1'b0;
    op(FEM_OP_MEM_RD, 16'h3FFF, 8'h00);
    chk(rd_v, 8'h42);
    access_pulse_width_sel <= 1'b1;
    @(posedge clk);
    chk({7'h0, flash_pulse_long}, 8'h01);
    av(1'b0, 4'h2, 32'h0);
    chk(q_v[7:0], 8'h00);
    // Reset in mid-run clears arm and steer
    op(FEM_OP_SFR_WR, 16'h00B2, 8'h03);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    op(FEM_OP_SFR_RD, 16'h00B2, 8'h00);
    chk(rd_v, 8'h00);
    end_of_test();
  end
endmodule : flash_erase_write_and_memory_map_tb_top
`default_nettype wire
